//--- design/csiab_auto_xfer.sv
// Automatic buffer transfer serial interface, transmit side, with APB registers.
// Assumes a serial peripheral sampling data on the rising serial clock edge.
//
// Register access over APB and the register offsets were left to the implementer.
`default_nettype none
module csiab_auto_xfer
    import csiab_pkg::*;
(
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    input  wire logic                       cpuHalt,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [csiab_pkg::AddrW-1:0] paddr,
    input  wire logic [csiab_pkg::DataW-1:0] pwdata,
    output logic                            pready,
    output logic      [csiab_pkg::DataW-1:0] prdata,
    output logic                            pslverr,
    output logic                            serialClockPin,
    output logic                            serialOutPin,
    output logic                            serialPinEn,
    output logic                            serialDoneIrq
);
    import csiab_pkg::*;

    csiab_state_t       state_r;
    logic [ModeW-1:0]   serialModeReg_r;
    logic [BufAw-1:0]   bufferEndPointer_r;
    logic [BufAw-1:0]   bufferAddrCounter_r;
    logic [GapW-1:0]    byteGapInterval_r;
    logic [DivW-1:0]    divisor_r;
    logic               xferBusyFlag_r;
    logic               xferDoneFlag_r;
    logic               stopReq_r;
    logic [7:0]         serialShiftReg_r;
    logic [2:0]         bitCnt_r;
    logic [GapW:0]      gapCnt_r;
    logic               sckTick;
    logic [7:0]         ramRdData;
    logic [BufAw-1:0]   ramRdAddr;
    logic               ramWrEn;

    // APB decode; a write or read completes on the edge where pready is high
    logic       apbAccess;
    logic       apbWr;
    logic       bufHit;
    logic       regHit;
    logic       autoStartTrigger;
    logic       autoStopTrigger;
    logic       doneClr;
    logic       modeOk;
    logic       byteDone;
    logic       lastByte;
    logic       repeatOn;
    logic       bitOrderLsb;
    logic       blockOff;

    assign apbAccess        = psel && penable && pready;
    assign apbWr            = apbAccess && pwrite;
    assign bufHit           = paddr[7];
    assign regHit           = (paddr == OffMode) || (paddr == OffTrigger)
                              || (paddr == OffStatus) || (paddr == OffEndPtr)
                              || (paddr == OffAddrCnt) || (paddr == OffGap)
                              || (paddr == OffDivisor);
    assign autoStartTrigger = apbWr && (paddr == OffTrigger) && pwdata[TrigStart];
    assign autoStopTrigger  = apbWr && (paddr == OffTrigger) && pwdata[TrigStop];
    assign doneClr          = apbWr && (paddr == OffStatus) && pwdata[StatDone];
    assign ramWrEn          = apbWr && bufHit;
    assign repeatOn         = serialModeReg_r[ModeRepeat];
    assign bitOrderLsb      = serialModeReg_r[ModeBitOrder];
    assign blockOff         = !serialModeReg_r[ModeBlockEn];
    // Receive must be off; repeat bit selects one-shot or repeat
    assign modeOk           = serialModeReg_r[ModeBlockEn] && serialModeReg_r[ModeAutoEn]
                              && serialModeReg_r[ModeTxEn]
                              && !serialModeReg_r[ModeRxEn];
    // Eighth rising serial clock edge ends the character
    assign byteDone         = (state_r == CSIAB_SHIFT) && sckTick && !cpuHalt
                              && serialClockPin == 1'b0 && bitCnt_r == LastBitIdx;
    assign lastByte         = (bufferAddrCounter_r == bufferEndPointer_r);
    // APB owns the read port whenever selected; engine fetch waits for it
    assign ramRdAddr        = psel ? paddr[BufAw+1:2] : bufferAddrCounter_r;

    csiab_buf_ram u_buf (
        .mclk   (mclk),
        .ce     (ce),
        .wrEn   (ramWrEn),
        .wrAddr (paddr[BufAw+1:2]),
        .wrData (pwdata[7:0]),
        .rdAddr (ramRdAddr),
        .rdData (ramRdData)
    );

    // Halt stops the divider and clears its count so the byte in flight pauses in place
    csiab_clk_div u_div (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .run     ((state_r == CSIAB_SHIFT || state_r == CSIAB_GAP) && !cpuHalt),
        .divisor (divisor_r),
        .tick    (sckTick)
    );

    // APB handshake: one wait state on every access
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (ce) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !bufHit && !regHit;
            if (psel && penable && !pready) begin
                prdata <= '0;
                if (bufHit) begin
                    prdata <= {24'h000000, ramRdData};
                end else begin
                    case (paddr)
                        OffMode:    prdata <= {26'h0, serialModeReg_r};
                        OffStatus:  prdata <= {30'h0, xferDoneFlag_r, xferBusyFlag_r};
                        OffEndPtr:  prdata <= {27'h0, bufferEndPointer_r};
                        OffAddrCnt: prdata <= {27'h0, bufferAddrCounter_r};
                        OffGap:     prdata <= {26'h0, byteGapInterval_r};
                        OffDivisor: prdata <= {24'h000000, divisor_r};
                        default:    prdata <= '0;
                    endcase
                end
            end
        end
    end

    // Configuration registers; software keeps them still while busy reads one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            serialModeReg_r    <= ModeReset;
            bufferEndPointer_r <= EndPtrReset;
            byteGapInterval_r  <= GapReset;
            divisor_r          <= DivReset;
        end else if (ce && apbWr) begin
            case (paddr)
                OffMode:    serialModeReg_r    <= pwdata[ModeW-1:0];
                OffEndPtr:  bufferEndPointer_r <= pwdata[BufAw-1:0];
                OffGap:     byteGapInterval_r  <= pwdata[GapW-1:0];
                OffDivisor: divisor_r          <= pwdata[DivW-1:0];
                default:    ;
            endcase
        end
    end

    // Done flag: a completion in the clearing cycle still sets it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xferDoneFlag_r <= 1'b0;
            serialDoneIrq  <= 1'b0;
        end else if (ce) begin
            serialDoneIrq <= 1'b0;
            if (byteDone && lastByte && !repeatOn && !stopReq_r) begin
                xferDoneFlag_r <= 1'b1;
                serialDoneIrq  <= 1'b1;
            end else if (doneClr) begin
                xferDoneFlag_r <= 1'b0;
            end
        end
    end

    // Stop request holds until the current byte boundary
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stopReq_r <= 1'b0;
        end else if (ce) begin
            if (state_r == CSIAB_IDLE || blockOff) begin
                stopReq_r <= 1'b0;
            end else if (autoStopTrigger) begin
                stopReq_r <= 1'b1;
            end
        end
    end

    // Sequencer and address counter
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r             <= CSIAB_IDLE;
            bufferAddrCounter_r <= '0;
            xferBusyFlag_r      <= 1'b0;
            gapCnt_r            <= '0;
        end else if (ce) begin
            if (blockOff) begin
                state_r             <= CSIAB_IDLE;
                bufferAddrCounter_r <= '0;
                xferBusyFlag_r      <= 1'b0;
            end else begin
                case (state_r)
                    CSIAB_IDLE: begin
                        // Resumes from the counter left by a suspension
                        if (autoStartTrigger && modeOk) begin
                            state_r        <= CSIAB_FETCH;
                            xferBusyFlag_r <= 1'b1;
                        end
                    end
                    CSIAB_FETCH: begin
                        if (!psel) begin
                            state_r <= CSIAB_LOAD;
                        end
                    end
                    CSIAB_LOAD: begin
                        state_r <= CSIAB_SHIFT;
                    end
                    CSIAB_SHIFT: begin
                        if (byteDone) begin
                            if (lastByte && !repeatOn) begin
                                // Full range sent: next start begins at the first byte
                                state_r             <= CSIAB_IDLE;
                                bufferAddrCounter_r <= '0;
                                xferBusyFlag_r      <= 1'b0;
                            end else begin
                                if (lastByte) begin
                                    bufferAddrCounter_r <= '0;
                                end else begin
                                    bufferAddrCounter_r <= bufferAddrCounter_r + 1'b1;
                                end
                                if (stopReq_r) begin
                                    state_r        <= CSIAB_IDLE;
                                    xferBusyFlag_r <= 1'b0;
                                end else begin
                                    state_r  <= CSIAB_GAP;
                                    gapCnt_r <= {byteGapInterval_r, 1'b0};
                                end
                            end
                        end
                    end
                    CSIAB_GAP: begin
                        // Two divider ticks per serial clock period
                        if (gapCnt_r == '0) begin
                            state_r <= CSIAB_FETCH;
                        end else if (sckTick && !cpuHalt) begin
                            gapCnt_r <= gapCnt_r - 1'b1;
                        end
                    end
                    default: begin
                        state_r <= CSIAB_IDLE;
                    end
                endcase
            end
        end
    end

    // Shift register and serial pins; the clock idles high
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            serialShiftReg_r <= '0;
            bitCnt_r         <= '0;
            serialClockPin   <= 1'b1;
            serialOutPin     <= 1'b1;
            serialPinEn      <= 1'b0;
        end else if (ce) begin
            serialPinEn <= xferBusyFlag_r && !blockOff;
            if (state_r == CSIAB_LOAD) begin
                serialShiftReg_r <= ramRdData;
                bitCnt_r         <= '0;
                serialClockPin   <= 1'b1;
            end else if (state_r == CSIAB_SHIFT && sckTick && !cpuHalt) begin
                if (serialClockPin) begin
                    // Falling edge: present the next bit, then move the register
                    serialClockPin <= 1'b0;
                    serialOutPin   <= bitOrderLsb ? serialShiftReg_r[0]
                                                  : serialShiftReg_r[7];
                    serialShiftReg_r <= bitOrderLsb ? {1'b0, serialShiftReg_r[7:1]}
                                                    : {serialShiftReg_r[6:0], 1'b0};
                end else begin
                    serialClockPin <= 1'b1;
                    bitCnt_r       <= bitCnt_r + 1'b1;
                end
            end else if (state_r == CSIAB_IDLE) begin
                serialClockPin <= 1'b1;
                serialOutPin   <= 1'b1;
            end
        end
    end
endmodule // csiab_auto_xfer
`default_nettype wire

//--- design/csiab_buf_ram.sv
// Transmit buffer RAM, one write port and one read port with registered data.
// Assumes both ports run on the system clock.
`default_nettype none
module csiab_buf_ram
    import csiab_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               ce,
    input  wire logic               wrEn,
    input  wire logic [csiab_pkg::BufAw-1:0] wrAddr,
    input  wire logic [7:0]                  wrData,
    input  wire logic [csiab_pkg::BufAw-1:0] rdAddr,
    output logic      [7:0]                  rdData
);
    import csiab_pkg::*;

    logic [7:0] mem [BufDepth];

    // No reset: contents are software data, read data is registered
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (wrEn) begin
                mem[wrAddr] <= wrData;
            end
            rdData <= mem[rdAddr];
        end
    end
endmodule // csiab_buf_ram
`default_nettype wire

//--- design/csiab_clk_div.sv
// Serial clock divider: one tick every (divisor + 1) system clocks while run is high.
// Assumes run drops whenever the serial clock must stand still.
`default_nettype none
module csiab_clk_div
    import csiab_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               run,
    input  wire logic [csiab_pkg::DivW-1:0] divisor,
    output logic                            tick
);
    import csiab_pkg::*;

    logic [DivW-1:0] count_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
            tick    <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                count_r <= '0;
                tick    <= 1'b0;
            end else if (count_r >= divisor) begin
                count_r <= '0;
                tick    <= 1'b1;
            end else begin
                count_r <= count_r + 1'b1;
                tick    <= 1'b0;
            end
        end
    end
endmodule // csiab_clk_div
`default_nettype wire

//--- shared/csiab_pkg.sv
// Constants shared by the automatic buffer transfer serial block.
// Assumes a 32-bit APB with byte addresses and one aligned word per register.
`default_nettype none
package csiab_pkg;
    localparam int          DataW        = 32;
    localparam int          AddrW        = 8;
    localparam int          BufAw        = 5;
    localparam int          BufDepth     = 32;
    localparam int          CharBits     = 8;
    localparam int          DivW         = 8;
    localparam int          GapW         = 6;

    localparam logic [7:0]  OffMode      = 8'h00;
    localparam logic [7:0]  OffTrigger   = 8'h04;
    localparam logic [7:0]  OffStatus    = 8'h08;
    localparam logic [7:0]  OffEndPtr    = 8'h0c;
    localparam logic [7:0]  OffAddrCnt   = 8'h10;
    localparam logic [7:0]  OffGap       = 8'h14;
    localparam logic [7:0]  OffDivisor   = 8'h18;
    localparam logic [7:0]  OffBufBase   = 8'h80;

    // Mode register fields
    localparam int          ModeBlockEn  = 0;
    localparam int          ModeAutoEn   = 1;
    localparam int          ModeRepeat   = 2;
    localparam int          ModeTxEn     = 3;
    localparam int          ModeRxEn     = 4;
    localparam int          ModeBitOrder = 5;
    localparam int          ModeW        = 6;
    // Trigger and status fields
    localparam int          TrigStart    = 0;
    localparam int          TrigStop     = 1;
    localparam int          StatBusy     = 0;
    localparam int          StatDone     = 1;

    localparam logic [ModeW-1:0] ModeReset    = 6'h00;
    localparam logic [GapW-1:0]  GapReset     = 6'h00;
    localparam logic [DivW-1:0]  DivReset     = 8'h03;
    localparam logic [BufAw-1:0] EndPtrReset  = 5'h00;
    localparam logic [2:0]       LastBitIdx   = 3'h7;

    typedef enum logic [2:0] {
        CSIAB_IDLE  = 3'b000,
        CSIAB_FETCH = 3'b001,
        CSIAB_LOAD  = 3'b010,
        CSIAB_SHIFT = 3'b011,
        CSIAB_GAP   = 3'b100
    } csiab_state_t;
endpackage
`default_nettype wire

//--- tb/csiab_auto_xfer_assertions.sv
// Port-level checker for the automatic buffer transfer serial block.
// Assumes one clock domain and binding onto csiab_auto_xfer.
`default_nettype none
module csiab_auto_xfer_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cpuHalt,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serialClockPin,
    input wire logic serialOutPin,
    input wire logic serialPinEn,
    input wire logic serialDoneIrq
);
    logic [15:0] fallCnt_r;
    logic        sckPrev_r;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Falls since the pins were taken; a frame must end on a whole byte
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sckPrev_r <= 1'b1;
            fallCnt_r <= 16'h0000;
        end else begin
            sckPrev_r <= serialClockPin;
            if (!serialPinEn) begin
                fallCnt_r <= 16'h0000;
            end else if (sckPrev_r && !serialClockPin) begin
                fallCnt_r <= fallCnt_r + 16'h0001;
            end
        end
    end
    a_apb_one_wait: assert property ((psel && !penable) ##1 (psel && penable) |=> pready)
        else $error("pready not in second access cycle");
    a_apb_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_irq_pulse: assert property (serialDoneIrq |=> !serialDoneIrq)
        else $error("done irq longer than one cycle");
    a_irq_frees_pins: assert property (serialDoneIrq |-> ##[0:3] !serialPinEn)
        else $error("pins still owned after done irq");
    a_sck_idle_high: assert property (!serialPinEn |-> serialClockPin)
        else $error("serial clock low outside transfer");
    a_data_idle_high: assert property (!serialPinEn && !$past(serialPinEn) |-> serialOutPin)
        else $error("serial data not idle outside transfer");
    // Also catches data moving together with a rising clock edge
    a_data_on_fall: assert property (
        serialPinEn && serialClockPin |-> $stable(serialOutPin))
        else $error("serial data moved while clock high");
    a_whole_bytes: assert property (
        $fell(serialPinEn) |-> fallCnt_r[2:0] == 3'h0 && fallCnt_r != 16'h0000)
        else $error("frame did not end on a byte boundary");
    a_halt_freeze: assert property ($past(cpuHalt) && serialPinEn
        |-> $stable(serialClockPin) && $stable(serialOutPin))
        else $error("serial pins moved during halt");
    c_irq: cover property (serialDoneIrq);
    c_halt: cover property (cpuHalt && serialPinEn);
    c_err: cover property (pslverr);
endmodule // csiab_auto_xfer_assertions

bind csiab_auto_xfer csiab_auto_xfer_assertions u_csiab_auto_xfer_assertions (
    .mclk(mclk), .rst(rst), .cpuHalt(cpuHalt), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .serialClockPin(serialClockPin),
    .serialOutPin(serialOutPin), .serialPinEn(serialPinEn), .serialDoneIrq(serialDoneIrq));
`default_nettype wire

//--- tb/csiab_auto_xfer_tb.sv
// Self-checking bench for the automatic buffer transfer serial block.
// Assumes the peripheral model and the bound checker are compiled first.
`default_nettype none
module csiab_auto_xfer_tb
    import csiab_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0, rst, ce, cpuHalt, psel, penable, pwrite, pready, pslverr;
    logic sck, sdo, pinEn, irq, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] rxCnt;
    logic [7:0]  bufData [6] = '{8'h81, 8'h3c, 8'ha5, 8'h0f, 8'hf0, 8'h5a};
    int err_total = 0, check_count = 0, irqCount = 0, enCyc = 0, base, k, c63;
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        if (irq === 1'b1) irqCount++;
        if (pinEn === 1'b1) enCyc++;
    end
    csiab_auto_xfer u_csiab_auto_xfer (.mclk(mclk), .rst(rst), .ce(ce), .cpuHalt(cpuHalt),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .serialClockPin(sck),
        .serialOutPin(sdo), .serialPinEn(pinEn), .serialDoneIrq(irq));
    csiab_periph_model u_csiab_periph_model (.sck(sck), .sdo(sdo), .en(pinEn), .rxCount(rxCnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // No local limit: the watchdog ends a hung access
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // 0 irq count, 1 bytes received, 2 pins released, 3 serial clock low
    task automatic waitUntil(input int s, input int n);
        int t;
        t = 0;
        while (!((s == 0 && irqCount >= n) || (s == 1 && rxCnt >= n) ||
                 (s == 2 && pinEn === 1'b0) || (s == 3 && sck === 1'b0)) && t < 20000) begin
            @(posedge mclk);
            t++;
        end
        if (t >= 20000) err_total++;
    endtask
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int j = 0; j < 8; j++) rev8[j] = b[7-j];
    endfunction
    task automatic bytesChk(input int n, input int m, input logic lsb);
        for (int i = 0; i < n; i++)
            chk(u_csiab_periph_model.rxLog[base+i], lsb ? rev8(bufData[i%m]) : bufData[i%m]);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge mclk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        {rst, ce, cpuHalt, psel, penable, pwrite, paddr, pwdata} = {3'b110, 43'h0};
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rdChk(OffMode, 32'h0);
        rdChk(OffDivisor, 32'h3);
        rdChk(OffGap, 32'h0);
        rdChk(OffAddrCnt, 32'h0);
        rdChk(OffStatus, 32'h0);
        rdChk(8'h40, 32'h0);
        chk(e, 1'b1);
        for (int i = 0; i < 6; i++) apb(1'b1, OffBufBase + 8'(4 * i), {24'h0, bufData[i]});
        $display("test reset done");
        base = rxCnt;
        apb(1'b1, OffEndPtr, 32'h5);
        apb(1'b1, OffMode, 32'h0b);
        apb(1'b1, OffTrigger, 32'h1);
        waitUntil(0, 1);
        bytesChk(6, 6, 1'b0);
        chk(rxCnt, base + 6);
        rdChk(OffStatus, 32'h2);
        rdChk(OffAddrCnt, 32'h0);
        $display("test single pass done");
        base = rxCnt;
        apb(1'b1, OffTrigger, 32'h1);
        waitUntil(1, base + 1);
        apb(1'b1, OffTrigger, 32'h2);
        waitUntil(2, 0);
        k = rxCnt - base;
        chk(k > 0 && k < 6, 1'b1);
        rdChk(OffAddrCnt, k);
        rdChk(OffStatus, 32'h2);
        chk(irqCount, 1);
        apb(1'b1, OffTrigger, 32'h1);
        waitUntil(0, 2);
        bytesChk(6, 6, 1'b0);
        chk(rxCnt, base + 6);
        $display("test suspend done");
        base = rxCnt;
        apb(1'b1, OffEndPtr, 32'h1);
        apb(1'b1, OffTrigger, 32'h1);
        waitUntil(3, 0);
        cpuHalt <= 1'b1;
        repeat (100) @(posedge mclk);
        chk(rxCnt, base);
        cpuHalt <= 1'b0;
        waitUntil(0, 3);
        bytesChk(2, 6, 1'b0);
        $display("test halt done");
        apb(1'b1, OffGap, 32'hff);
        rdChk(OffGap, 32'h3f);
        c63 = enCyc;
        apb(1'b1, OffTrigger, 32'h1);
        waitUntil(0, 4);
        c63 = enCyc - c63;
        apb(1'b1, OffGap, 32'h0);
        k = enCyc;
        apb(1'b1, OffTrigger, 32'h1);
        waitUntil(0, 5);
        chk(c63 - (enCyc - k), 63 * 2 * (int'(DivReset) + 1));
        $display("test gap done");
        base = rxCnt;
        apb(1'b1, OffMode, 32'h2f);
        apb(1'b1, OffTrigger, 32'h1);
        waitUntil(1, base + 5);
        chk(irqCount, 5);
        apb(1'b1, OffTrigger, 32'h2);
        waitUntil(2, 0);
        k = rxCnt - base;
        bytesChk(k, 2, 1'b1);
        rdChk(OffAddrCnt, k % 2);
        $display("test repeat done");
        tally_and_finish();
    end
endmodule // csiab_auto_xfer_tb
`default_nettype wire

//--- tb/csiab_periph_model.sv
// Behavioural serial peripheral that receives bytes from the block.
// Assumes the serial clock idles high and moves only within frames.
`default_nettype none
module csiab_periph_model (
    input  wire logic        sck,
    input  wire logic        sdo,
    input  wire logic        en,
    output logic      [15:0] rxCount
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rxLog [64];
    logic [7:0] sh;
    int         nBits;
    initial begin
        rxCount = 16'h0000;
        nBits = 0;
        sh = 8'h00;
    end
    // First bit lands in bit 7, so the log shows wire order
    // Only edges inside a frame count; the clock leaving reset is not a bit
    always @(posedge sck) begin
        if (en === 1'b1) begin
            sh = {sh[6:0], sdo};
            nBits++;
            if (nBits == 8) begin
                rxLog[rxCount[5:0]] = sh;
                rxCount++;
                nBits = 0;
            end
        end
    end
endmodule // csiab_periph_model
`default_nettype wire
